// file: hw/cdpc_defines.svh
`ifndef CDPC_DEFINES_SVH
`define CDPC_DEFINES_SVH
`define CDPC_CLK_NS      4
`define CDPC_FRAME_NS    136000
`define CDPC_LOCK_HZ     460
`define CDPC_REF_HALF    7'h40
`define CDPC_ADDR_CTRL   8'h00
`define CDPC_ADDR_VSET   8'h04
`define CDPC_ADDR_STAT   8'h08
`define CDPC_MODE_CLVN   2'h0
`define CDPC_MODE_CLVW   2'h1
`define CDPC_MODE_CAVW   2'h2
`define CDPC_CTRL_LOW_POWER_SELECT   2
`define CDPC_CTRL_PWMSEL 3
`define CDPC_CTRL_SLOFF  4
`define CDPC_CTRL_SYNC_WINDOW_SELECT   5
`define CDPC_CTRL_INTERP 6
`define CDPC_CTRL_RESET  7'h00
`define CDPC_VSET_RESET  8'h1f
`define CDPC_NOM_VEL     8'h1f
`define CDPC_ST_MON_LSB  2
`define CDPC_ST_VEL_LSB  8
`define CDPC_FWD_LAST    4'hc
`define CDPC_BACK_LAST   2'h2
`define CDPC_WIN_NARROW  16'h0008
`define CDPC_WIN_WIDE    16'h0020
`define CDPC_FRAME_CH    16'h024c
`define CDPC_LOCK_LAST   4'h7
`define CDPC_C1_MAX      3'h2
`define CDPC_C2_MAX      3'h4
`define CDPC_RUN_MIN     4'h3
`define CDPC_RUN_MAX     4'hb
`define CDPC_DPLL_NOM    16'h046d
`define CDPC_DPLL_SPAN   16'h0027
`endif

// file: hw/cdpc_pkg.sv
package cdpc_pkg;
  typedef enum logic [2:0] {
    SYN_HUNT = 3'b001,
    SYN_BACK = 3'b010,
    SYN_LOCK = 3'b100
  } cdpc_sync_state_t;
endpackage : cdpc_pkg

// file: hw/cdpc_vel_meas.sv
`timescale 1ns/1ps
`include "cdpc_defines.svh"
module cdpc_vel_meas (
  input  wire logic       clk_sys,
  input  wire logic       rst,
  input  wire logic       velClkSync,
  output logic [7:0]      velocityValue
);
  logic [6:0] refCnt_q;
  logic       velPrev_q;
  logic       half_q;
  logic [7:0] cnt_q;
  logic       refHigh;
  logic       halfRise;

  // Reference is the crystal clock over 128: high for the first half
  assign refHigh  = refCnt_q < `CDPC_REF_HALF;
  assign halfRise = velClkSync & ~velPrev_q & half_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refCnt_q  <= 7'h00;
      velPrev_q <= 1'b0;
      half_q    <= 1'b0;
    end else begin
      refCnt_q  <= refCnt_q + 7'h01;
      velPrev_q <= velClkSync;
      if (velClkSync & ~velPrev_q)
        half_q <= ~half_q;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_q         <= 8'h00;
      velocityValue <= 8'h00;
    end else begin
      if (refCnt_q == 7'h00)
        cnt_q <= 8'h00;
      else if (refHigh && halfRise && cnt_q != 8'hff)
        cnt_q <= cnt_q + 8'h01;
      if (refCnt_q == `CDPC_REF_HALF)
        velocityValue <= cnt_q;
    end
  end
endmodule : cdpc_vel_meas

// file: hw/cdpc_dpll.sv
`timescale 1ns/1ps
`include "cdpc_defines.svh"
module cdpc_dpll (
  input  wire logic clk_sys,
  input  wire logic rst,
  input  wire logic efmSync,
  input  wire logic secondaryLoopOff,
  output logic      chanTick,
  output logic      runError
);
  logic [15:0]        acc_q;
  logic [15:0]        freq_q;
  logic               efmPrev_q;
  logic [3:0]         run_q;
  logic               edgeSeen;
  logic signed [15:0] phaseErr;
  logic [16:0]        sum;

  assign edgeSeen = efmSync ^ efmPrev_q;
  assign phaseErr = $signed(acc_q);
  assign sum      = {1'b0, acc_q} + {1'b0, freq_q};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      acc_q     <= 16'h0000;
      efmPrev_q <= 1'b0;
      chanTick  <= 1'b0;
    end else begin
      efmPrev_q <= efmSync;
      chanTick  <= sum[16];
      // Phase loop pulls the boundary toward each EFM transition
      if (edgeSeen)
        acc_q <= sum[15:0] - 16'(phaseErr >>> 2);
      else
        acc_q <= sum[15:0];
    end
  end

  // Frequency loop off keeps the rate at nominal; only the narrow
  // phase loop remains, which trades capture range for 3T/4T jitter
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      freq_q <= `CDPC_DPLL_NOM;
    else if (secondaryLoopOff)
      freq_q <= `CDPC_DPLL_NOM;
    else if (edgeSeen && phaseErr > 0 && freq_q < `CDPC_DPLL_NOM + `CDPC_DPLL_SPAN)
      freq_q <= freq_q + 16'h0001;
    else if (edgeSeen && phaseErr < 0 && freq_q > `CDPC_DPLL_NOM - `CDPC_DPLL_SPAN)
      freq_q <= freq_q - 16'h0001;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      run_q    <= 4'h0;
      runError <= 1'b0;
    end else begin
      runError <= edgeSeen && (run_q < `CDPC_RUN_MIN || run_q > `CDPC_RUN_MAX);
      if (edgeSeen)
        run_q <= 4'h0;
      else if (chanTick && run_q != 4'hf)
        run_q <= run_q + 4'h1;
    end
  end
endmodule : cdpc_dpll

// file: hw/cdpc_playback_ctrl.sv
`timescale 1ns/1ps
`include "cdpc_defines.svh"
module cdpc_playback_ctrl #(
  parameter int FRAME_CYCLES = `CDPC_FRAME_NS / `CDPC_CLK_NS,
  parameter int LOCK_CYCLES  = 1000000000 / (`CDPC_LOCK_HZ * `CDPC_CLK_NS)
) (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        velocityCountClock,
  input  wire logic        efmIn,
  input  wire logic        frameSyncIn,
  input  wire logic        externalSpindlePwmIn,
  input  wire logic        corrValid,
  input  wire logic        corrStage2,
  input  wire logic [2:0]  corrErrCount,
  input  wire logic        corrFail,
  input  wire logic        efmBadIn,
  input  wire logic        c1PtrIn,
  input  wire logic        sampleValid,
  input  wire logic [15:0] sampleData,
  input  wire logic        samplePtr,
  output logic             spindlePhaseAccel,
  output logic             spindlePhaseBrake,
  output logic             channelTick,
  output logic             fsTick,
  output logic             frameSyncGood,
  output logic             velocityLockFlag,
  output logic [7:0]       velocityValue,
  output logic [3:0]       correctionMonitor,
  output logic             c1PtrOut,
  output logic             c2PtrOut,
  output logic             concealValid,
  output logic [15:0]      concealData
);
  logic [1:0]  velSync_q, efmSync_q, fsySync_q, pwmSync_q;
  logic        velS, efmS, fsyS, pwmS;
  logic [6:0]  ctrl_q;
  logic [7:0]  vset_q;
  logic        ack_q;
  logic [1:0]  mode;
  logic        lowPowerSelect, spindlePwmModeSelect, secondaryLoopOff;
  logic        syncWindowSelect, interpSelect;
  logic        cav, clvw;
  logic        runError;
  logic [7:0]  target;

  // Pin synchronisers, two flops each; only bit 1 is read downstream
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      velSync_q <= 2'h0;
      efmSync_q <= 2'h0;
      fsySync_q <= 2'h0;
      pwmSync_q <= 2'h0;
    end else begin
      velSync_q <= {velSync_q[0], velocityCountClock};
      efmSync_q <= {efmSync_q[0], efmIn};
      fsySync_q <= {fsySync_q[0], frameSyncIn};
      pwmSync_q <= {pwmSync_q[0], externalSpindlePwmIn};
    end
  end
  assign velS = velSync_q[1];
  assign efmS = efmSync_q[1];
  assign fsyS = fsySync_q[1];
  assign pwmS = pwmSync_q[1];

  assign mode                 = ctrl_q[1:0];
  assign lowPowerSelect       = ctrl_q[`CDPC_CTRL_LOW_POWER_SELECT];
  assign spindlePwmModeSelect = ctrl_q[`CDPC_CTRL_PWMSEL];
  assign secondaryLoopOff     = ctrl_q[`CDPC_CTRL_SLOFF];
  assign syncWindowSelect     = ctrl_q[`CDPC_CTRL_SYNC_WINDOW_SELECT];
  assign interpSelect         = ctrl_q[`CDPC_CTRL_INTERP];
  assign cav                  = mode == `CDPC_MODE_CAVW;
  assign clvw                 = mode == `CDPC_MODE_CLVW;

  // Bus slave: one wait state, read data loaded while waitrequest is high
  assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack_q        <= 1'b0;
      avs_readdata <= 32'h00000000;
      ctrl_q       <= `CDPC_CTRL_RESET;
      vset_q       <= `CDPC_VSET_RESET;
    end else begin
      ack_q <= (avs_read | avs_write) & ~ack_q;
      if (avs_read && !ack_q) begin
        if (avs_address == `CDPC_ADDR_CTRL)
          avs_readdata <= {25'h0, ctrl_q};
        else if (avs_address == `CDPC_ADDR_VSET)
          avs_readdata <= {24'h0, vset_q};
        else if (avs_address == `CDPC_ADDR_STAT)
          avs_readdata <= {16'h0, velocityValue, 2'h0, correctionMonitor, frameSyncGood, velocityLockFlag};
        else
          avs_readdata <= 32'h00000000;
      end
      if (avs_write && ack_q) begin
        if (avs_address == `CDPC_ADDR_CTRL)
          ctrl_q <= avs_writedata[6:0];
        else if (avs_address == `CDPC_ADDR_VSET)
          vset_q <= avs_writedata[7:0];
      end
    end
  end

  cdpc_vel_meas uVel (
    .clk_sys       (clk_sys),
    .rst           (rst),
    .velClkSync    (velS),
    .velocityValue (velocityValue)
  );

  cdpc_dpll uDpll (
    .clk_sys          (clk_sys),
    .rst              (rst),
    .efmSync          (efmS),
    .secondaryLoopOff (secondaryLoopOff),
    .chanTick         (channelTick),
    .runError         (runError)
  );

  // Spindle drive: angular mode aims at the written setting
  assign target = cav ? vset_q : `CDPC_NOM_VEL;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      spindlePhaseAccel <= 1'b0;
      spindlePhaseBrake <= 1'b0;
    end else if (cav && spindlePwmModeSelect) begin
      spindlePhaseAccel <= pwmS;
      spindlePhaseBrake <= ~pwmS;
    end else begin
      // Wide linear ignores the PWM select and uses only this pair
      spindlePhaseAccel <= velocityValue < target;
      spindlePhaseBrake <= velocityValue > target && !(clvw && lowPowerSelect);
    end
  end

  // Frame timing: crystal-based, or channel-clock-based in angular mode
  cdpc_pkg::cdpc_sync_state_t syncState_q;
  logic [15:0] frmCnt_q;
  logic [15:0] frmLast;
  logic [15:0] win;
  logic        unitTick;
  logic        inWindow;
  logic        decide;
  logic        seen_q;
  logic [3:0]  missCnt_q;
  logic [1:0]  backCnt_q;
  logic        syncPrev_q;
  logic        syncEdge;

  assign unitTick = cav ? channelTick : 1'b1;
  assign frmLast  = cav ? `CDPC_FRAME_CH - 16'h0001 : 16'(FRAME_CYCLES - 1);
  assign win      = syncWindowSelect ? `CDPC_WIN_NARROW : `CDPC_WIN_WIDE;
  assign inWindow = frmCnt_q <= win || frmCnt_q > frmLast - win;
  assign decide   = unitTick && frmCnt_q == win;
  assign syncEdge = fsyS & ~syncPrev_q;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      frmCnt_q   <= 16'h0000;
      fsTick     <= 1'b0;
      syncPrev_q <= 1'b0;
    end else begin
      syncPrev_q <= fsyS;
      fsTick     <= unitTick && frmCnt_q == frmLast;
      if (syncState_q == cdpc_pkg::SYN_HUNT && syncEdge)
        frmCnt_q <= 16'h0001;
      else if (unitTick)
        frmCnt_q <= (frmCnt_q >= frmLast) ? 16'h0000 : frmCnt_q + 16'h0001;
    end
  end

  // Sync seen in window; a new sync wins over the decision clear
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      seen_q <= 1'b0;
    else if (syncEdge && inWindow && syncState_q != cdpc_pkg::SYN_HUNT)
      seen_q <= 1'b1;
    else if (decide)
      seen_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      syncState_q   <= cdpc_pkg::SYN_HUNT;
      missCnt_q     <= 4'h0;
      backCnt_q     <= 2'h0;
      frameSyncGood <= 1'b0;
    end else begin
      case (syncState_q)
        cdpc_pkg::SYN_HUNT: begin
          frameSyncGood <= 1'b0;
          if (syncEdge) begin
            syncState_q <= cdpc_pkg::SYN_BACK;
            backCnt_q   <= 2'h0;
          end
        end
        cdpc_pkg::SYN_BACK: begin
          if (decide) begin
            frameSyncGood <= seen_q;
            if (seen_q) begin
              syncState_q <= cdpc_pkg::SYN_LOCK;
              missCnt_q   <= 4'h0;
            end else if (backCnt_q == `CDPC_BACK_LAST)
              syncState_q <= cdpc_pkg::SYN_HUNT;
            else
              backCnt_q <= backCnt_q + 2'h1;
          end
        end
        cdpc_pkg::SYN_LOCK: begin
          if (decide) begin
            frameSyncGood <= seen_q;
            if (seen_q)
              missCnt_q <= 4'h0;
            else if (missCnt_q == `CDPC_FWD_LAST)
              syncState_q <= cdpc_pkg::SYN_HUNT;
            else
              missCnt_q <= missCnt_q + 4'h1;
          end
        end
        default: syncState_q <= cdpc_pkg::SYN_HUNT;
      endcase
    end
  end

  // Lock flag from 460 Hz samples of frame-sync-good
  logic [19:0] lockCnt_q;
  logic [3:0]  hiRun_q, loRun_q;
  logic        lockSample;

  assign lockSample = lockCnt_q == 20'(LOCK_CYCLES - 1);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      lockCnt_q        <= 20'h00000;
      hiRun_q          <= 4'h0;
      loRun_q          <= 4'h0;
      velocityLockFlag <= 1'b0;
    end else begin
      lockCnt_q <= lockSample ? 20'h00000 : lockCnt_q + 20'h00001;
      if (lockSample && frameSyncGood) begin
        loRun_q <= 4'h0;
        hiRun_q <= (hiRun_q == `CDPC_LOCK_LAST) ? hiRun_q : hiRun_q + 4'h1;
        if (hiRun_q == `CDPC_LOCK_LAST)
          velocityLockFlag <= 1'b1;
      end else if (lockSample) begin
        hiRun_q <= 4'h0;
        loRun_q <= (loRun_q == `CDPC_LOCK_LAST) ? loRun_q : loRun_q + 4'h1;
        if (loRun_q == `CDPC_LOCK_LAST)
          velocityLockFlag <= 1'b0;
      end
    end
  end

  // Correction monitor and pointers
  logic runErrSeen_q;
  logic c1Ptr;
  logic c1Uncorr, c2Uncorr;

  assign c1Uncorr = corrFail || corrErrCount > `CDPC_C1_MAX;
  assign c2Uncorr = corrFail || corrErrCount > `CDPC_C2_MAX;
  // Pointer marks risky bytes so the second stage treats them as erasures
  assign c1Ptr = c1Uncorr || corrErrCount == `CDPC_C1_MAX || efmBadIn
                 || runErrSeen_q || !velocityLockFlag;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst)
      runErrSeen_q <= 1'b0;
    else if (runError)
      runErrSeen_q <= 1'b1;
    else if (corrValid && !corrStage2)
      runErrSeen_q <= 1'b0;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      correctionMonitor <= 4'h0;
      c1PtrOut          <= 1'b0;
      c2PtrOut          <= 1'b0;
    end else if (corrValid && !corrStage2) begin
      c1PtrOut <= c1Ptr;
      if (c1Uncorr)
        correctionMonitor <= 4'h7;
      else
        correctionMonitor <= {1'b0, c1Ptr, corrErrCount[1:0]};
    end else if (corrValid) begin
      if (!c2Uncorr) begin
        correctionMonitor <= {1'b1, corrErrCount};
        c2PtrOut          <= 1'b0;
      end else if (c1PtrIn) begin
        correctionMonitor <= 4'he;
        c2PtrOut          <= c1PtrIn;
      end else begin
        correctionMonitor <= 4'hf;
        c2PtrOut          <= 1'b1;
      end
    end
  end

  // Concealment runs one sample late so interpolation can see the next one
  logic [15:0] cur_q;
  logic        curPtr_q, curValid_q;
  logic [16:0] avgSum;

  assign avgSum = {concealData[15], concealData} + {sampleData[15], sampleData};

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cur_q        <= 16'h0000;
      curPtr_q     <= 1'b0;
      curValid_q   <= 1'b0;
      concealValid <= 1'b0;
      concealData  <= 16'h0000;
    end else begin
      concealValid <= sampleValid && curValid_q;
      if (sampleValid) begin
        cur_q      <= sampleData;
        curPtr_q   <= samplePtr;
        curValid_q <= 1'b1;
        if (curValid_q && !curPtr_q)
          concealData <= cur_q;
        else if (curValid_q && interpSelect && !samplePtr)
          concealData <= avgSum[16:1];
      end
    end
  end

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (rst);

  sequence clvwLowPwr;
    clvw && lowPowerSelect && !(cav && spindlePwmModeSelect);
  endsequence
  sequence lockMissLast;
    syncState_q == cdpc_pkg::SYN_LOCK && decide && !seen_q && missCnt_q == `CDPC_FWD_LAST;
  endsequence

  low_power_brake_a: assert property (clvwLowPwr ##1 clvwLowPwr |-> !spindlePhaseBrake)
    else $error("brake pulse in low power wide linear mode");
  pwm_kick_a: assert property (cav && spindlePwmModeSelect |=> spindlePhaseAccel == $past(pwmS)
    && spindlePhaseBrake != spindlePhaseAccel)
    else $error("external pwm not followed");
  wide_linear_drive_a: assert property (clvw ##1 clvw |-> spindlePhaseAccel == ($past(velocityValue) < `CDPC_NOM_VEL))
    else $error("wide linear drive not from phase compare");
  fwd_protect_a: assert property (lockMissLast |=> syncState_q == cdpc_pkg::SYN_HUNT)
    else $error("window not opened after 13 misses");
  back_protect_a: assert property (syncState_q == cdpc_pkg::SYN_BACK && decide && !seen_q
    && backCnt_q == `CDPC_BACK_LAST |=> syncState_q == cdpc_pkg::SYN_HUNT)
    else $error("window not reopened after 3 frames");
  lock_rise_a: assert property ($rose(velocityLockFlag) |-> $past(hiRun_q) == `CDPC_LOCK_LAST
    && $past(frameSyncGood))
    else $error("lock flag rose too early");
  monitor_hold_a: assert property (!corrValid |=> $stable(correctionMonitor))
    else $error("monitor changed without correction");
  c1_fail_code_a: assert property (corrValid && !corrStage2 && corrFail |=> correctionMonitor == 4'h7)
    else $error("wrong first stage failure code");
  c2_fail_ptr_a: assert property (corrValid && corrStage2 && corrFail |=> correctionMonitor[3:1] == 3'h7
    && (c2PtrOut || correctionMonitor == 4'he))
    else $error("second stage failure not flagged");
  conceal_hold_a: assert property (sampleValid && curValid_q && curPtr_q && !interpSelect
    |=> concealValid && $stable(concealData))
    else $error("bad sample not held");
endmodule : cdpc_playback_ctrl

// file: verification/cdpc_host_model.sv
`timescale 1ns/1ps
module cdpc_host_model (
  input  wire logic        clk_sys,
  output logic [7:0]       avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic [31:0]      avs_writedata,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  initial begin
    avs_address   = 8'h00;
    avs_read      = 1'h0;
    avs_write     = 1'h0;
    avs_writedata = 32'h0;
  end
  // Request held until waitrequest is seen low at an edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
    @(posedge clk_sys);
    avs_address   <= a;
    avs_writedata <= wd;
    avs_read      <= !wr;
    avs_write     <= wr;
    @(posedge clk_sys);
    while (avs_waitrequest) @(posedge clk_sys);
    rd = avs_readdata;
    avs_read  <= 1'h0;
    avs_write <= 1'h0;
  endtask : xfer
  // Wide linear only once lock reads high, with PWM select low
  task automatic spin_up;
    logic [31:0] d;
    xfer(1'h1, 8'h00, 32'h12, d);
    xfer(1'h0, 8'h08, 32'h0, d);
    if (d[0]) xfer(1'h1, 8'h00, 32'h01, d);
  endtask : spin_up
  task automatic watch_lock;
    logic [31:0] d;
    xfer(1'h0, 8'h08, 32'h0, d);
    if (!d[0]) xfer(1'h1, 8'h00, 32'h12, d);
  endtask : watch_lock
endmodule : cdpc_host_model

// file: verification/cdpc_playback_ctrl_tb.sv
`timescale 1ns/1ps
module cdpc_playback_ctrl_tb;
  logic        clk_sys, rst, velClk, syncOn, frameSyncIn, pwmIn;
  logic        corrValid, corrStage2, corrFail, c1PtrIn, rd, wr, waitReq;
  logic        accel, brake, fsGood, lockFlag, c2Ptr;
  logic        sampleValid, samplePtr, c1Ptr, concValid, fsTickW;
  logic [15:0] sampleData, concData;
  logic [2:0]  corrErrCount, velCnt;
  logic [3:0]  monitor;
  logic [7:0]  addr, velValue;
  logic [31:0] wdata, rdata, d;
  int          failures, samplesChecked, cycles, frameCnt, fsTicks, syncAt;
  cdpc_host_model host (.clk_sys(clk_sys), .avs_address(addr), .avs_read(rd), .avs_write(wr),
    .avs_writedata(wdata), .avs_readdata(rdata), .avs_waitrequest(waitReq));
  cdpc_playback_ctrl #(.FRAME_CYCLES(200), .LOCK_CYCLES(50)) uut (.clk_sys(clk_sys), .rst(rst),
    .avs_address(addr), .avs_read(rd), .avs_write(wr), .avs_writedata(wdata), .avs_readdata(rdata),
    .avs_waitrequest(waitReq), .velocityCountClock(velClk), .efmIn(1'h0), .frameSyncIn(frameSyncIn),
    .externalSpindlePwmIn(pwmIn), .corrValid(corrValid), .corrStage2(corrStage2),
    .corrErrCount(corrErrCount), .corrFail(corrFail), .efmBadIn(1'h0), .c1PtrIn(c1PtrIn),
    .sampleValid(sampleValid), .sampleData(sampleData), .samplePtr(samplePtr), .spindlePhaseAccel(accel),
    .spindlePhaseBrake(brake), .channelTick(), .fsTick(fsTickW), .frameSyncGood(fsGood),
    .velocityLockFlag(lockFlag), .velocityValue(velValue), .correctionMonitor(monitor),
    .c1PtrOut(c1Ptr), .c2PtrOut(c2Ptr), .concealValid(concValid), .concealData(concData));
  initial begin
    clk_sys = 1'h0;
    forever #2 clk_sys = ~clk_sys;
  end
  // Sync every 200 cycles; count clock period 8 cycles
  always @(posedge clk_sys) begin
    frameCnt    <= (frameCnt == 199) ? 0 : frameCnt + 1;
    frameSyncIn <= syncOn && frameCnt >= syncAt && frameCnt < syncAt + 4;
    if (fsTickW) fsTicks <= fsTicks + 1;
    velCnt      <= velCnt + 3'h1;
    velClk      <= velCnt[2];
    cycles      <= cycles + 1;
    if (cycles == 30000) begin
      failures++;
      report_and_stop;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samplesChecked++;
    if (seen !== exp) begin
      failures++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", samplesChecked, failures);
    if (failures == 0 && samplesChecked > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : report_and_stop
  task automatic corr(input logic s2, input logic [2:0] n, input logic f, input logic c1, input logic [3:0] exp);
    corrStage2   <= s2;
    corrErrCount <= n;
    corrFail     <= f;
    c1PtrIn      <= c1;
    corrValid    <= 1'h1;
    @(posedge clk_sys);
    corrValid <= 1'h0;
    repeat (4) @(posedge clk_sys);
    chk("monitor", {28'h0, monitor}, {28'h0, exp});
  endtask : corr
  task automatic t_regs;
    host.xfer(1'h0, 8'h00, 32'h0, d);
    chk("ctrl", d, 32'h0);
    host.xfer(1'h0, 8'h04, 32'h0, d);
    chk("vset", d, 32'h1f);
    host.xfer(1'h0, 8'h3c, 32'h0, d);
    chk("unmapped", d, 32'h0);
    $display("test regs done");
  endtask : t_regs
  // Lock still low, so every first-stage result carries the pointer
  task automatic t_corr;
    for (int i = 0; i < 3; i++) corr(1'h0, i[2:0], 1'h0, 1'h0, {2'h1, i[1:0]});
    chk("c1ptr", {31'h0, c1Ptr}, 32'h1);
    corr(1'h0, 3'h3, 1'h0, 1'h0, 4'h7);
    corr(1'h0, 3'h0, 1'h1, 1'h0, 4'h7);
    for (int i = 0; i < 5; i++) corr(1'h1, i[2:0], 1'h0, 1'h0, {1'h1, i[2:0]});
    chk("c2ptr clear", {31'h0, c2Ptr}, 32'h0);
    corr(1'h1, 3'h5, 1'h0, 1'h1, 4'he);
    chk("c2ptr copy", {31'h0, c2Ptr}, 32'h1);
    corr(1'h1, 3'h0, 1'h1, 1'h0, 4'hf);
    chk("c2ptr set", {31'h0, c2Ptr}, 32'h1);
    $display("test corr done");
  endtask : t_corr
  // Output checked at the falling edge, half a cycle after the strobe
  task automatic samp(input logic [15:0] v, input logic p, input logic ev, input logic [15:0] exp);
    sampleData  <= v;
    samplePtr   <= p;
    sampleValid <= 1'h1;
    @(posedge clk_sys);
    sampleValid <= 1'h0;
    @(negedge clk_sys);
    chk("conceal valid", {31'h0, concValid}, {31'h0, ev});
    chk("conceal data", {16'h0, concData}, {16'h0, exp});
    @(posedge clk_sys);
  endtask : samp
  task automatic t_conceal;
    samp(16'h0100, 1'h0, 1'h0, 16'h0000);
    samp(16'h0200, 1'h0, 1'h1, 16'h0100);
    samp(16'h7fff, 1'h1, 1'h1, 16'h0200);
    samp(16'h0400, 1'h0, 1'h1, 16'h0200);
    host.xfer(1'h1, 8'h00, 32'h40, d);
    samp(16'h7fff, 1'h1, 1'h1, 16'h0400);
    samp(16'h0600, 1'h0, 1'h1, 16'h0500);
    $display("test conceal done");
  endtask : t_conceal
  // Half-rate count clock is one pulse per 16 cycles: 4 in 64
  task automatic t_vel;
    int f0;
    f0 = fsTicks;
    repeat (400) @(posedge clk_sys);
    chk("frame ticks", fsTicks - f0, 32'h2);
    chk("velocity", {24'h0, velValue}, 32'h4);
    host.xfer(1'h0, 8'h08, 32'h0, d);
    chk("stat velocity", {24'h0, d[15:8]}, 32'h4);
    $display("test velocity done");
  endtask : t_vel
  task automatic t_pwm;
    host.xfer(1'h1, 8'h00, 32'h1a, d);
    pwmIn <= 1'h1;
    repeat (8) @(posedge clk_sys);
    chk("kick", {30'h0, accel, brake}, 32'h2);
    pwmIn <= 1'h0;
    repeat (8) @(posedge clk_sys);
    chk("brake", {30'h0, accel, brake}, 32'h1);
    host.xfer(1'h1, 8'h00, 32'h12, d);
    host.xfer(1'h1, 8'h04, 32'h02, d);
    repeat (4) @(posedge clk_sys);
    chk("slow set", {30'h0, accel, brake}, 32'h1);
    host.xfer(1'h1, 8'h04, 32'h40, d);
    repeat (4) @(posedge clk_sys);
    chk("fast set", {30'h0, accel, brake}, 32'h2);
    host.xfer(1'h1, 8'h04, 32'h1f, d);
    host.xfer(1'h1, 8'h00, 32'h0, d);
    $display("test pwm done");
  endtask : t_pwm
  task automatic t_sync;
    syncOn <= 1'h1;
    repeat (4000) @(posedge clk_sys);
    chk("sync good", {31'h0, fsGood}, 32'h1);
    chk("lock", {31'h0, lockFlag}, 32'h1);
    host.spin_up;
    host.xfer(1'h0, 8'h00, 32'h0, d);
    chk("wide linear", d, 32'h01);
    host.xfer(1'h1, 8'h00, 32'h05, d);
    repeat (8) @(posedge clk_sys);
    chk("low power", {30'h0, accel, brake}, 32'h2);
    syncOn <= 1'h0;
    while (lockFlag) @(posedge clk_sys);
    host.watch_lock;
    host.xfer(1'h0, 8'h00, 32'h0, d);
    chk("back angular", d, 32'h12);
    host.xfer(1'h1, 8'h00, 32'h0, d);
    repeat (3400) @(posedge clk_sys);
    chk("sync lost", {31'h0, fsGood}, 32'h0);
    chk("lock lost", {31'h0, lockFlag}, 32'h0);
    // Shifted syncs fall outside a locked window; only an opened one takes them
    syncAt <= 100;
    syncOn <= 1'h1;
    repeat (1000) @(posedge clk_sys);
    chk("resync", {31'h0, fsGood}, 32'h1);
    $display("test sync done");
  endtask : t_sync
  initial begin
    {rst, syncOn, pwmIn, frameSyncIn, velClk, velCnt} = 8'h80;
    {corrValid, corrStage2, corrFail, c1PtrIn, corrErrCount, sampleValid, samplePtr, sampleData} = 25'h0000000;
    {failures, samplesChecked, cycles, frameCnt, fsTicks, syncAt} = 192'h0;
    repeat (10) @(posedge clk_sys);
    rst <= 1'h0;
    t_regs;
    t_corr;
    t_conceal;
    t_vel;
    t_pwm;
    t_sync;
    report_and_stop;
  end
endmodule : cdpc_playback_ctrl_tb
